// [src/ecpo_pkg.sv]
`default_nettype none
// shared constants for the enhanced capture/compare/pwm output stage
package ecpo_pkg;
   // register byte offsets on the wishbone bus
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CMPV = 8'h04;
   localparam logic [7:0] OFF_PCFG = 8'h08;
   localparam logic [7:0] OFF_ASD = 8'h0C;
   localparam logic [7:0] OFF_DIR = 8'h10;
   localparam logic [7:0] OFF_LAT = 8'h14;
   localparam logic [7:0] OFF_IST = 8'h18;
   localparam logic [7:0] OFF_IMSK = 8'h1C;
   localparam logic [7:0] OFF_STAT = 8'h20;
   // unit_mode_select codes
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_4 = 4'h6;
   localparam logic [3:0] MODE_CAP_16 = 4'h7;
   localparam logic [3:0] MODE_CMP_SET = 4'h8;
   localparam logic [3:0] MODE_CMP_CLR = 4'h9;
   localparam logic [3:0] MODE_CMP_IRQ = 4'hA;
   localparam logic [3:0] MODE_CMP_SPEV = 4'hB;
   localparam logic [1:0] MODE_GRP_CAP = 2'h1;
   localparam logic [1:0] MODE_GRP_CMP = 2'h2;
   localparam logic [1:0] MODE_GRP_PWM = 2'h3;
   // output_config_select codes
   localparam logic [1:0] OCFG_SINGLE = 2'h0;
   localparam logic [1:0] OCFG_FWD = 2'h1;
   localparam logic [1:0] OCFG_HALF = 2'h2;
   localparam logic [1:0] OCFG_REV = 2'h3;
   // field positions
   localparam int CTRL_OCFG_LSB = 6;
   localparam int CTRL_DUTY_LSB = 4;
   localparam int PCFG_RESTART_BIT = 7;
   localparam int ASD_STATUS_BIT = 7;
   localparam int ASD_SRC_BIT = 4;
   localparam int ASD_AC_LSB = 2;
   localparam int ASD_BD_LSB = 0;
   localparam int IRQ_EVENT = 0;
   localparam int IRQ_SHUT = 1;
   // shutdown pin states (any other code floats the pin)
   localparam logic [1:0] SHUT_DRIVE0 = 2'h0;
   localparam logic [1:0] SHUT_DRIVE1 = 2'h1;
   // reset values and capture prescale limits
   localparam logic [3:0] DIR_RESET = 4'hF;
   localparam logic [3:0] CAP_PRE4 = 4'h3;
   localparam logic [3:0] CAP_PRE16 = 4'hF;
   localparam logic [6:0] DB_ZERO = 7'h00;
   localparam logic [6:0] DB_ONE = 7'h01;
   typedef enum logic [1:0] {ECPO_RUN, ECPO_SHUT, ECPO_WAIT} ecpo_shut_t;
endpackage
`default_nettype wire

// [src/ecpo_top.sv]
// What this block does
// R1: up to four pwm channels, set by mode
// R2: channels a-d share port pins by mode
// R3: software sets mode bits and clears directions
// R4: compare uses timer one/three, pwm timer two
// R5: capture/compare behave like the standard unit
// R6: special event clears selected timer count
// R7: compare value acts as 16-bit period
// R8: direction 0 drives compare output, 1 captures
// R9: channel a overrides latch, floats on shutdown
// R10: half-bridge drives a and complement on b
// R11: dead-band delays active edges, may suppress
// R12: cleared shutdown resumes at next period
// R13: reset makes pins inputs, registers default
// R14: per-channel enable to the port logic
`timescale 1ns/1ps
`default_nettype none
module ecpo_top
   import ecpo_pkg::*;
(
   input wire logic clk_i, // 250 MHz core clock
   input wire logic rst_i, // synchronous, active high
   input wire logic wb_cyc_i, // bus cycle
   input wire logic wb_stb_i, // bus strobe
   input wire logic wb_we_i, // write enable
   input wire logic [7:0] wb_adr_i, // byte address
   input wire logic [3:0] wb_sel_i, // byte lanes
   input wire logic [31:0] wb_dat_i, // write data
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // acknowledge
   input wire logic [15:0] timer1_count_i, // first timer count
   input wire logic [15:0] timer3_count_i, // third timer count
   input wire logic timer3_select_i, // 1: third timer is time base
   input wire logic [9:0] timer2_count_i, // pwm time base
   input wire logic period_start_i, // one-cycle pulse, new pwm period
   input wire logic capture_pin_i, // pin level of channel a
   input wire logic fault_pin_i, // external shutdown source
   output logic [3:0] pwm_pin_o, // pin levels, d..a
   output logic [3:0] pwm_pin_oe_o, // high while pin is driven
   output logic [3:0] chan_enable_o, // channel owns its pin
   output logic timer1_clear_o, // clear first timer count
   output logic timer3_clear_o, // clear third timer count
   output logic irq_o // level interrupt
);
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction
   // byte-lane merge of an 8-bit field
   function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] nw,
                                       input logic en);
      lane = en ? nw : old;
   endfunction
   logic [31:0] rdat_reg, rdat_next;
   logic [15:0] cmpv_reg, cmpv_next, sel_cnt;
   logic [9:0] duty;
   logic [7:0] ctrl_reg, ctrl_next, pcfg_reg, pcfg_next;
   logic [6:0] asd_reg, asd_next, db_reg, db_next;
   logic [3:0] dir_reg, dir_next, lat_reg, lat_next, cap_cnt_reg, cap_cnt_next;
   logic [3:0] chan_reg, chan_next, pin_reg, oe_reg, pin_next, oe_next, mode, wave;
   logic [3:0] drive_act, shut_lvl, shut_flt;
   logic [1:0] ist_reg, ist_next, imsk_reg, imsk_next, ocfg;
   logic ack_reg, ack_next, irq_reg, irq_next, cmp_out_reg, cmp_out_next, match_prev_reg;
   logic cap_s1_reg, cap_s2_reg, cap_prev_reg, flt_s1_reg, flt_s2_reg, raw_prev_reg;
   logic t1_clr_reg, t1_clr_next, t3_clr_reg, t3_clr_next;
   ecpo_shut_t st_reg, st_next;
   logic is_pwm, is_cap, is_cmp, bus_wr, force_shut, clear_shut, fault_req;
   logic match, match_rise, cap_edge, cap_take, raw, raw_chg, db_on, spev;
   // decoded mode and time base
   assign mode = ctrl_reg[3:0];
   assign ocfg = ctrl_reg[CTRL_OCFG_LSB +: 2];
   assign is_pwm = (mode[3:2] == MODE_GRP_PWM);
   assign is_cap = (mode[3:2] == MODE_GRP_CAP);
   assign is_cmp = (mode[3:2] == MODE_GRP_CMP);
   assign sel_cnt = timer3_select_i ? timer3_count_i : timer1_count_i; // see R4
   assign match = is_cmp && (sel_cnt == cmpv_reg);
   assign match_rise = match && !match_prev_reg;
   assign spev = match_rise && (mode == MODE_CMP_SPEV);
   assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;
   assign fault_req = flt_s2_reg && asd_reg[ASD_SRC_BIT];
   assign force_shut = bus_wr && hit(wb_adr_i, OFF_ASD) && wb_sel_i[0]
                       && wb_dat_i[ASD_STATUS_BIT];
   assign clear_shut = bus_wr && hit(wb_adr_i, OFF_ASD) && wb_sel_i[0]
                       && !wb_dat_i[ASD_STATUS_BIT];
   // capture edge and prescaler, same behaviour as the standard unit
   always_comb begin
      cap_edge = 1'b0;
      if (mode == MODE_CAP_FALL) begin
         cap_edge = cap_prev_reg && !cap_s2_reg;
      end else if (is_cap) begin
         cap_edge = !cap_prev_reg && cap_s2_reg;
      end
      cap_cnt_next = is_cap ? cap_cnt_reg : 4'h0;
      cap_take = 1'b0;
      if (cap_edge) begin
         if ((mode == MODE_CAP_4 && cap_cnt_reg == CAP_PRE4) ||
             (mode == MODE_CAP_16 && cap_cnt_reg == CAP_PRE16) ||
             mode == MODE_CAP_FALL || mode == MODE_CAP_RISE) begin
            cap_take = 1'b1; // see R5
            cap_cnt_next = 4'h0;
         end else begin
            cap_cnt_next = cap_cnt_reg + 4'h1;
         end
      end
   end
   // register file, compare output and timer clears
   always_comb begin
      ctrl_next = ctrl_reg;
      cmpv_next = cmpv_reg;
      pcfg_next = pcfg_reg;
      asd_next = asd_reg;
      dir_next = dir_reg;
      lat_next = lat_reg;
      imsk_next = imsk_reg;
      rdat_next = rdat_reg;
      ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
      if (bus_wr) begin
         if (hit(wb_adr_i, OFF_CTRL)) begin
            ctrl_next = lane(ctrl_reg, wb_dat_i[7:0], wb_sel_i[0]); // see R3
         end else if (hit(wb_adr_i, OFF_CMPV)) begin
            cmpv_next[7:0] = lane(cmpv_reg[7:0], wb_dat_i[7:0], wb_sel_i[0]);
            cmpv_next[15:8] = lane(cmpv_reg[15:8], wb_dat_i[15:8], wb_sel_i[1]);
         end else if (hit(wb_adr_i, OFF_PCFG)) begin
            pcfg_next = lane(pcfg_reg, wb_dat_i[7:0], wb_sel_i[0]);
         end else if (hit(wb_adr_i, OFF_ASD) && wb_sel_i[0]) begin
            asd_next = wb_dat_i[6:0];
         end else if (hit(wb_adr_i, OFF_DIR) && wb_sel_i[0]) begin
            dir_next = wb_dat_i[3:0]; // see R3
         end else if (hit(wb_adr_i, OFF_LAT) && wb_sel_i[0]) begin
            lat_next = wb_dat_i[3:0];
         end else if (hit(wb_adr_i, OFF_IMSK) && wb_sel_i[0]) begin
            imsk_next = wb_dat_i[1:0];
         end
      end
      // a capture lands after the bus write so the hardware value wins
      if (cap_take) begin
         cmpv_next = sel_cnt; // see R5
      end
      if (ack_next) begin
         rdat_next = 32'h0000_0000; // unmapped offsets read zero
         if (hit(wb_adr_i, OFF_CTRL)) begin
            rdat_next[7:0] = ctrl_reg;
         end else if (hit(wb_adr_i, OFF_CMPV)) begin
            rdat_next[15:0] = cmpv_reg;
         end else if (hit(wb_adr_i, OFF_PCFG)) begin
            rdat_next[7:0] = pcfg_reg;
         end else if (hit(wb_adr_i, OFF_ASD)) begin
            rdat_next[7:0] = {st_reg == ECPO_SHUT, asd_reg};
         end else if (hit(wb_adr_i, OFF_DIR)) begin
            rdat_next[3:0] = dir_reg;
         end else if (hit(wb_adr_i, OFF_LAT)) begin
            rdat_next[3:0] = lat_reg;
         end else if (hit(wb_adr_i, OFF_IST)) begin
            rdat_next[1:0] = ist_reg;
         end else if (hit(wb_adr_i, OFF_IMSK)) begin
            rdat_next[1:0] = imsk_reg;
         end else if (hit(wb_adr_i, OFF_STAT)) begin
            rdat_next[7:0] = {pin_reg, chan_reg};
         end
      end
      // write-one-to-clear, but a new event in the same cycle wins
      ist_next = ist_reg;
      if (bus_wr && hit(wb_adr_i, OFF_IST) && wb_sel_i[0]) begin
         ist_next = ist_reg & ~wb_dat_i[1:0];
      end
      if (match_rise || cap_take) begin
         ist_next[IRQ_EVENT] = 1'b1;
      end
      if (st_reg != ECPO_SHUT && st_next == ECPO_SHUT) begin
         ist_next[IRQ_SHUT] = 1'b1;
      end
      irq_next = |(ist_next & imsk_next);
      cmp_out_next = is_cmp ? cmp_out_reg : 1'b0;
      if (match_rise && mode == MODE_CMP_SET) begin
         cmp_out_next = 1'b1;
      end else if (match_rise && mode == MODE_CMP_CLR) begin
         cmp_out_next = 1'b0;
      end
      t1_clr_next = spev && !timer3_select_i; // see R6
      t3_clr_next = spev && timer3_select_i; // see R7
   end
   // shutdown sequencing; a cleared shutdown waits for the period edge
   always_comb begin
      st_next = st_reg;
      case (st_reg)
         ECPO_RUN: begin
            if (fault_req || force_shut) begin
               st_next = ECPO_SHUT;
            end
         end
         ECPO_SHUT: begin
            // clearing is ignored while the fault is still present
            if (!fault_req && (pcfg_reg[PCFG_RESTART_BIT] || clear_shut)) begin
               st_next = ECPO_WAIT; // see R12
            end
         end
         ECPO_WAIT: begin
            if (fault_req || force_shut) begin
               st_next = ECPO_SHUT;
            end else if (period_start_i) begin
               st_next = ECPO_RUN; // see R12
            end
         end
         default: begin
            st_next = ECPO_RUN;
         end
      endcase
   end
   // pwm shaping with dead band on the half-bridge pair
   assign duty = {cmpv_reg[7:0], ctrl_reg[CTRL_DUTY_LSB +: 2]};
   assign raw = is_pwm && (timer2_count_i < duty); // see R4
   assign raw_chg = (raw != raw_prev_reg);
   assign db_on = raw_chg ? (pcfg_reg[6:0] == DB_ZERO) : (db_reg == DB_ZERO); // see R11
   always_comb begin
      db_next = db_reg;
      if (raw_chg) begin
         db_next = (pcfg_reg[6:0] == DB_ZERO) ? DB_ZERO : pcfg_reg[6:0] - DB_ONE;
      end else if (db_reg != DB_ZERO) begin
         db_next = db_reg - DB_ONE;
      end
      case (ocfg)
         OCFG_SINGLE: wave = {3'h0, raw};
         OCFG_HALF: wave = {2'h0, !raw && db_on, raw && db_on}; // see R10
         OCFG_FWD: wave = {raw, 3'h1};
         default: wave = {2'h1, raw, 1'b0};
      endcase
      wave = wave ^ {mode[0], mode[1], mode[0], mode[1]};
      if (!is_pwm) begin
         wave = {3'h0, cmp_out_reg};
      end
      chan_next = 4'h0; // see R1
      if (is_pwm) begin
         case (ocfg)
            OCFG_SINGLE: chan_next = 4'h1;
            OCFG_HALF: chan_next = 4'h3;
            default: chan_next = 4'hF;
         endcase
      end else if (mode != MODE_OFF) begin
         chan_next = 4'h1;
      end
   end
   // per-pin override of the port latch
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_pin
         localparam int SL = (gi % 2 == 0) ? ASD_AC_LSB : ASD_BD_LSB;
         assign drive_act[gi] = chan_next[gi] && !is_cap && !dir_reg[gi]; // see R8
         assign shut_lvl[gi] = (asd_reg[SL +: 2] == SHUT_DRIVE1);
         assign shut_flt[gi] = is_pwm && st_reg != ECPO_RUN
                               && asd_reg[SL +: 2] != SHUT_DRIVE0
                               && asd_reg[SL +: 2] != SHUT_DRIVE1;
         assign pin_next[gi] = !drive_act[gi] ? lat_reg[gi] : // see R2
                               (is_pwm && st_reg != ECPO_RUN) ? shut_lvl[gi] : wave[gi];
         assign oe_next[gi] = drive_act[gi] ? !shut_flt[gi] : !dir_reg[gi]; // see R9
      end
   endgenerate
   // all state; reset leaves every pin an input
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= 8'h00; // see R13
         cmpv_reg <= 16'h0000;
         pcfg_reg <= 8'h00;
         asd_reg <= 7'h00;
         dir_reg <= DIR_RESET;
         lat_reg <= 4'h0;
         ist_reg <= 2'h0;
         imsk_reg <= 2'h0;
         rdat_reg <= 32'h0000_0000;
         ack_reg <= 1'b0;
         irq_reg <= 1'b0;
         cap_s1_reg <= 1'b0;
         cap_s2_reg <= 1'b0;
         cap_prev_reg <= 1'b0;
         flt_s1_reg <= 1'b0;
         flt_s2_reg <= 1'b0;
         cap_cnt_reg <= 4'h0;
         match_prev_reg <= 1'b0;
         cmp_out_reg <= 1'b0;
         t1_clr_reg <= 1'b0;
         t3_clr_reg <= 1'b0;
         st_reg <= ECPO_RUN;
         raw_prev_reg <= 1'b0;
         db_reg <= DB_ZERO;
         chan_reg <= 4'h0;
         pin_reg <= 4'h0;
         oe_reg <= 4'h0;
      end else begin
         ctrl_reg <= ctrl_next;
         cmpv_reg <= cmpv_next;
         pcfg_reg <= pcfg_next;
         asd_reg <= asd_next;
         dir_reg <= dir_next;
         lat_reg <= lat_next;
         ist_reg <= ist_next;
         imsk_reg <= imsk_next;
         rdat_reg <= rdat_next;
         ack_reg <= ack_next;
         irq_reg <= irq_next;
         cap_s1_reg <= capture_pin_i;
         cap_s2_reg <= cap_s1_reg;
         cap_prev_reg <= cap_s2_reg;
         flt_s1_reg <= fault_pin_i;
         flt_s2_reg <= flt_s1_reg;
         cap_cnt_reg <= cap_cnt_next;
         match_prev_reg <= match;
         cmp_out_reg <= cmp_out_next;
         t1_clr_reg <= t1_clr_next;
         t3_clr_reg <= t3_clr_next;
         st_reg <= st_next;
         raw_prev_reg <= raw;
         db_reg <= db_next;
         chan_reg <= chan_next; // see R14
         pin_reg <= pin_next;
         oe_reg <= oe_next;
      end
   end
   assign wb_dat_o = rdat_reg;
   assign wb_ack_o = ack_reg;
   assign pwm_pin_o = pin_reg;
   assign pwm_pin_oe_o = oe_reg;
   assign chan_enable_o = chan_reg;
   assign timer1_clear_o = t1_clr_reg;
   assign timer3_clear_o = t3_clr_reg;
   assign irq_o = irq_reg;
   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_chan_off_idle: assert property ( // see R1
      (mode == MODE_OFF) |=> (chan_enable_o == 4'h0))
      else $error("channel enabled with unit off");
   a_quad_all_on: assert property ( // see R2
      (is_pwm && ocfg[0]) |=> (chan_enable_o == 4'hF))
      else $error("full bridge without four channels");
   a_half_complement: assert property ( // see R10
      (is_pwm && ocfg == OCFG_HALF && st_reg == ECPO_RUN && dir_reg[1:0] == 2'h0
       && mode[1:0] == 2'h0 && db_on) |=> (pwm_pin_o[1] == !pwm_pin_o[0]))
      else $error("half bridge outputs not complementary");
   a_spev_clear: assert property ( // see R6
      spev |=> (timer1_clear_o != timer3_clear_o))
      else $error("special event did not clear one timer");
   a_clear_source: assert property ( // see R7
      timer1_clear_o |-> !$past(timer3_select_i))
      else $error("first timer cleared while third selected");
   a_deadband_hold: assert property ( // see R11
      (is_pwm && ocfg == OCFG_HALF && $rose(raw) && pcfg_reg[6:0] != DB_ZERO
       && mode[1:0] == 2'h0 && st_reg == ECPO_RUN && !dir_reg[0]) |=> !pwm_pin_o[0])
      else $error("active edge not delayed by dead band");
   a_shut_float: assert property ( // see R9
      (is_pwm && st_reg == ECPO_SHUT && shut_flt[0]) |=> !pwm_pin_oe_o[0])
      else $error("channel a driven during floating shutdown");
   a_resume_wait: assert property ( // see R12
      (st_reg == ECPO_WAIT && is_pwm && !dir_reg[0] && !period_start_i && !fault_req
       && !force_shut) |=> (st_reg == ECPO_WAIT) ##0 (pwm_pin_o[0] == $past(shut_lvl[0])))
      else $error("pwm resumed before period start");
   a_cmp_override: assert property ( // see R8
      (is_cmp && !dir_reg[0]) |=> (pwm_pin_oe_o[0] && pwm_pin_o[0] == $past(cmp_out_reg)))
      else $error("compare output not on pin");
   a_reset_inputs: assert property ( // see R13
      $fell(rst_i) |-> (dir_reg == DIR_RESET && pwm_pin_oe_o == 4'h0 && ctrl_reg == 8'h00))
      else $error("reset did not release pins");
   a_capture_load: assert property ( // see R5
      cap_take |=> (cmpv_reg == $past(sel_cnt)))
      else $error("capture did not load compare value");
   c_spev: cover property (spev ##1 timer1_clear_o);
   c_shut_resume: cover property ((st_reg == ECPO_WAIT) ##1 (st_reg == ECPO_RUN));
   c_half_db: cover property (is_pwm && ocfg == OCFG_HALF && raw_chg && !db_on);
   c_capture: cover property (cap_take && mode == MODE_CAP_16);
endmodule
`default_nettype wire

// [verif/ecpo_bridge_model.sv]
`timescale 1ns/1ps
`default_nettype none
// power stage as seen from the four channel pins
module ecpo_bridge_model (
   input wire logic [3:0] pin_i, // levels offered by the block
   input wire logic [3:0] oe_i, // high while the block drives a pin
   output logic [3:0] wire_o // resolved level on each pin
);
   // pull-downs keep the switches off; a released pin never keeps its last level
   assign wire_o = pin_i & oe_i;
endmodule
`default_nettype wire

// [verif/ecpo_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module ecpo_top_bench
   import ecpo_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [15:0] timer1_count_i = 16'h0000;
   logic [15:0] timer3_count_i = 16'h0000;
   logic timer3_select_i = 1'b0;
   logic [9:0] timer2_count_i = 10'h000;
   logic period_start_i = 1'b0;
   logic fault_pin_i = 1'b0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, timer1_clear_o, timer3_clear_o, irq_o, probe;
   logic [3:0] pwm_pin_o, pwm_pin_oe_o, chan_enable_o, pin_wire;
   int n_fail = 0;
   int samples_checked = 0;
   integer seed = 32'hb8cd_61d8;
   logic [31:0] r;
   logic [15:0] v;
   logic [3:0] pe;
   logic [31:0] rd_q[$];
   logic [1:0] clr_q[$];
   logic [25:0] pr_q[$];

   ecpo_top i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .timer1_count_i, .timer3_count_i, .timer3_select_i,
      .timer2_count_i, .period_start_i, .capture_pin_i(pin_wire[0]), .fault_pin_i,
      .pwm_pin_o, .pwm_pin_oe_o, .chan_enable_o, .timer1_clear_o, .timer3_clear_o, .irq_o);
   ecpo_bridge_model i_bridge (.pin_i(pwm_pin_o), .oe_i(pwm_pin_oe_o), .wire_o(pin_wire));

   // 250 MHz clock
   initial begin
      forever #2 clk_i = ~clk_i;
   end

   // one comparison, counted; a miss is reported at once
   task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // classic single cycle; the request stands until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      wb(1'b0, a, 32'h0000_0000);
   endtask

   // probe vector is {irq, oe[3:0], pin[3:0], enable[3:0]}; only masked bits count
   task automatic chk(input logic [12:0] m, input logic [12:0] e);
      pr_q.push_back({m, e & m});
      @(posedge clk_i);
      probe <= 1'b1;
      @(posedge clk_i);
      probe <= 1'b0;
   endtask

   task automatic pulse();
      @(posedge clk_i);
      period_start_i <= 1'b1;
      @(posedge clk_i);
      period_start_i <= 1'b0;
   endtask

   // watcher: every result that shows up takes the oldest note of its kind
   always @(posedge clk_i) begin
      logic [25:0] p;
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
         cmp("read data", rd_q.size() ? rd_q.pop_front() : 'x, wb_dat_o);
      if (timer1_clear_o === 1'b1 || timer3_clear_o === 1'b1)
         cmp("timer clear", clr_q.size() ? clr_q.pop_front() : 'x,
            {timer3_clear_o, timer1_clear_o});
      if (probe === 1'b1) begin
         p = pr_q.size() ? pr_q.pop_front() : 'x;
         cmp("pins", p[12:0], p[25:13] & {irq_o, pwm_pin_oe_o, pwm_pin_o, chan_enable_o});
      end
   end

   // watchdog sized well above the few hundred cycles the sequence needs
   initial begin
      #40000;
      n_fail++;
      stop_test();
   end

   // main sequence
   initial begin
      probe = 1'b0;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      chk(13'h1FFF, 13'h0000);
      rd(OFF_DIR, 32'h0000_000F);
      rd(OFF_CTRL, 32'h0000_0000);
      rd(8'h30, 32'h0000_0000);
      r = $random(seed);
      wb(1'b1, OFF_LAT, r);
      rd(OFF_LAT, {28'h000_0000, r[3:0]});
      wb(1'b1, OFF_IMSK, 32'h0000_0003);
      // the unselected count also matches, so a wrong pick of time base shows
      for (int s = 0; s < 2; s++) begin
         v = $random(seed) | 16'h0002;
         wb(1'b1, OFF_CMPV, {16'h0000, v});
         wb(1'b1, OFF_CTRL, {28'h000_0000, MODE_CMP_SPEV});
         timer3_select_i <= 1'(s);
         timer1_count_i <= s ? v : v - 16'h0001;
         timer3_count_i <= s ? v - 16'h0001 : v;
         tick(4);
         clr_q.push_back(s ? 2'h2 : 2'h1);
         if (s) timer3_count_i <= v;
         else timer1_count_i <= v;
         tick(4);
         chk(13'h1000, 13'h1000);
         rd(OFF_IST, 32'h0000_0001);
         wb(1'b1, OFF_IST, 32'h0000_0001);
         rd(OFF_IST, 32'h0000_0000);
         timer1_count_i <= 16'h0000;
         timer3_count_i <= 16'h0000;
      end
      // set-on-match drives channel a; channel b is not owned, so its latch shows
      wb(1'b1, OFF_CTRL, {28'h000_0000, MODE_CMP_SET});
      wb(1'b1, OFF_DIR, 32'h0000_000C);
      timer3_count_i <= v;
      tick(4);
      chk(13'h0330, {5'h03, 2'h0, r[1], 1'b1, 4'h0});
      wb(1'b1, OFF_DIR, 32'h0000_000F);
      chk(13'h0100, 13'h0000);
      wb(1'b1, OFF_IST, 32'h0000_0003);
      // every output configuration in pwm mode
      wb(1'b1, OFF_CMPV, 32'h0000_0040);
      wb(1'b1, OFF_DIR, 32'h0000_0000);
      for (int k = 0; k < 4; k++) begin
         wb(1'b1, OFF_CTRL, {24'h00_0000, 2'(k), 2'h0, 4'hC});
         pulse();
         tick(3);
         // unowned pins show the latch; full bridge: one side steady, the other modulated
         pe = k == 0 ? {r[3:1], 1'b1} : (k == 1 ? 4'h9 : (k == 2 ? {r[3:2], 2'h1} : 4'h6));
         chk(13'h00FF, {5'h00, pe, k == 0 ? 4'h1 : (k == 2 ? 4'h3 : 4'hF)});
      end
      wb(1'b1, OFF_CTRL, {24'h00_0000, OCFG_HALF, 2'h0, 4'hC});
      pulse();
      tick(4);
      chk(13'h0330, 13'h0310);
      timer2_count_i <= 10'h3FF;
      pulse();
      tick(4);
      chk(13'h0330, 13'h0320);
      // dead band of 16 cycles holds back the active edge of b
      wb(1'b1, OFF_PCFG, 32'h0000_0010);
      timer2_count_i <= 10'h000;
      tick(30);
      timer2_count_i <= 10'h3FF;
      tick(6);
      chk(13'h0020, 13'h0000);
      tick(16);
      chk(13'h0020, 13'h0020);
      // fault: a floats, b drives 0; output returns only at the next period
      wb(1'b1, OFF_ASD, 32'h0000_0018);
      fault_pin_i <= 1'b1;
      tick(6);
      chk(13'h1320, 13'h1200);
      fault_pin_i <= 1'b0;
      tick(4);
      wb(1'b1, OFF_ASD, 32'h0000_0018);
      tick(4);
      chk(13'h0100, 13'h0000);
      pulse();
      tick(4);
      chk(13'h0100, 13'h0100);
      wb(1'b1, OFF_IST, 32'h0000_0003);
      chk(13'h1000, 13'h0000);
      // capture: channel a's latch loops back through the pin as the capture input
      wb(1'b1, OFF_CTRL, {28'h000_0000, MODE_CAP_RISE});
      wb(1'b1, OFF_LAT, 32'h0000_0000);
      timer3_count_i <= v ^ 16'h5A5A;
      wb(1'b1, OFF_LAT, 32'h0000_0001);
      tick(6);
      rd(OFF_CMPV, {16'h0000, v ^ 16'h5A5A});
      rd(OFF_IST, 32'h0000_0001);
      tick(4);
      if (rd_q.size() + clr_q.size() + pr_q.size() != 0)
         n_fail++;
      stop_test();
   end
endmodule
`default_nettype wire
